// ---- asptx_consts.svh ----
// Constants for the asynchronous serial port: register byte offsets,
// field positions and reset values.
// Assumes a 32-bit AHB-Lite slave where each register is one aligned word.
`ifndef ASPTX_CONSTS_SVH
`define ASPTX_CONSTS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define ASPTX_OFS_TXSC 8'h00
`define ASPTX_OFS_RXSC 8'h04
`define ASPTX_OFS_BAUD 8'h08
`define ASPTX_OFS_DIVL 8'h0C
`define ASPTX_OFS_DIVH 8'h10
`define ASPTX_OFS_TXH 8'h14
`define ASPTX_OFS_RXR 8'h18
`define ASPTX_OFS_FLAG 8'h1C

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ASPTX_TX_NINE 6
`define ASPTX_TX_EN 5
`define ASPTX_TX_SYNC 4
`define ASPTX_TX_FAST 2
`define ASPTX_TX_TRMT 1
`define ASPTX_TX_D9 0
`define ASPTX_RX_PEN 7
`define ASPTX_RX_NINE 6
`define ASPTX_RX_REN 4
`define ASPTX_RX_FRM 2
`define ASPTX_RX_OVR 1
`define ASPTX_RX_D9 0
`define ASPTX_BD_INV 4
`define ASPTX_BD_WIDE 3
`define ASPTX_FL_TXE 0
`define ASPTX_FL_RXA 1
`define ASPTX_FL_TXIE 2
`define ASPTX_FL_GIE 3
`define ASPTX_FL_PIE 4

// ------------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------------
`define ASPTX_RST_BYTE 8'h00
`define ASPTX_OVS_LAST 4'hF
`define ASPTX_START_MID 4'h7
`define ASPTX_FIFO_DEPTH 2

`endif

// ---- asptx_pkg.sv ----
// Types shared by the asynchronous serial port.
// Assumes the constants header is compiled alongside.
package asptx_pkg;

   // Control bits that software writes, gathered as one carrier.
   typedef struct packed {
      logic pen;
      logic sync;
      logic txon;
      logic rxon;
      logic t9;
      logic rx9;
      logic fast;
      logic wide;
      logic inv;
   } asptx_ctrl_t;

   // One received character with its framing status.
   typedef struct packed {
      logic frm;
      logic [8:0] data;
   } asptx_char_t;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asptx_rxst_t;

endpackage : asptx_pkg

// ---- asptx_top.sv ----
// Asynchronous serial transmitter and receiver with an AHB-Lite slave.
// Assumes serial_in_pin and all bus inputs are synchronous to clk.
`include "asptx_consts.svh"

// Functional notes
// RULE1 - Port works asynchronously only when clocked mode clear and port enabled.
// RULE2 - Nine-bit enable sends nine data bits; set ninth bit marks address.
// RULE3 - Polarity invert flips transmitted serial data and idle level.
// RULE4 - Setting transmit enable sets transmit buffer empty flag.
// RULE5 - Interrupt raised at once when all enables meet empty flag. Here registered, one clock later.
// RULE6 - Ninth bit loaded first; writing holding register starts transmission.
// RULE7 - Divisor bytes and speed selects set the baud rate.
// RULE8 - Receive recovery runs at sixteen ticks per bit period.
// RULE9 - Complete characters enter a two-entry receive FIFO immediately.
// RULE10 - Receiver active only with receive enable, async mode, port enabled.
// RULE11 - Reception begins on a falling edge of the input while idle.
// RULE12 - Half a bit after the edge the start centre must be low.
// RULE13 - High start centre abandons the character silently.
// RULE14 - Each later bit centre one bit apart, decided by majority.
// RULE15 - Stop sample low sets framing error, high clears it.
// RULE16 - After the stop bit the character enters FIFO, available flag set.
// RULE17 - Reading receive register returns and removes oldest character.
// RULE18 - Pending overrun blocks further reception until cleared.
// RULE19 - Unimplemented register bits read as zero.
// RULE20 - Empty transmitter loads shift register at once, else after stop.
// RULE21 - Empty flag clear only when busy and holding full; read only. Here clear whenever holding full, busy or not.
// RULE22 - Third character into full FIFO sets overrun; disables clear it.
// RULE23 - Framing flag follows oldest character; cleared by port disable.
// RULE24 - Majority of three oversampled values decides each bit.
module asptx_top
   import asptx_pkg::*;
#(
   parameter int DEPTH = `ASPTX_FIFO_DEPTH
) (
   input wire logic clk, // System clock, 20 MHz.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size, word only.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready in.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Always OKAY.
   input wire logic serial_in_pin, // Receive line.
   output logic serial_out_pin, // Transmit line.
   output logic serial_out_oe_n, // Low while transmit pin is driven.
   output logic tx_irq // Transmit interrupt request.
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Majority of three samples, used for start, data and stop bits.
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj3

   asptx_ctrl_t ctrl_r;
   logic [7:0] divl_r, divh_r;
   logic d9_r, txie_r, gie_r, pie_r;
   logic tx_act, rx_act;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_nxt;
   logic take, rd_pop;

   // RULE1 asynchronous enable gating
   assign tx_act = ctrl_r.pen & ~ctrl_r.sync & ctrl_r.txon;
   // RULE10 receiver enable gating
   assign rx_act = ctrl_r.pen & ~ctrl_r.sync & ctrl_r.rxon;

   assign take = hsel & hready & htrans[1];
   assign rd_pop = take & ~hwrite & (haddr[7:0] == `ASPTX_OFS_RXR);

   // ------------------------------------------------------------------
   // Baud tick generator
   // ------------------------------------------------------------------
   logic [15:0] bcnt_r;
   logic [1:0] pre_r;
   logic tick_r;
   logic [15:0] div_val;

   // RULE7 divisor and speed selects
   assign div_val = ctrl_r.wide ? {divh_r, divl_r} : {8'h00, divl_r};

   // One oversample tick every div+1 clocks, four times slower without
   // high speed; the divider runs only while the port is enabled.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bcnt_r <= 16'h0000;
         pre_r <= 2'h0;
         tick_r <= 1'b0;
      end else if (!ctrl_r.pen) begin
         bcnt_r <= 16'h0000;
         pre_r <= 2'h0;
         tick_r <= 1'b0;
      end else if (bcnt_r >= div_val) begin
         bcnt_r <= 16'h0000;
         pre_r <= pre_r + 2'h1;
         tick_r <= ctrl_r.fast | (pre_r == 2'h3);
      end else begin
         bcnt_r <= bcnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------------
   logic [7:0] hold_r;
   logic hold9_r, hold_v_r;
   logic busy_r;
   logic [10:0] tshift_r;
   logic [3:0] tph_r, tbits_r;
   logic hold_wr, tx_done, load_shift;

   assign hold_wr = wr_pend_r & (wr_addr_r == `ASPTX_OFS_TXH);
   assign tx_done = busy_r & tick_r & (tph_r == `ASPTX_OVS_LAST) &
                    (tbits_r == 4'h1);
   // RULE20 straight load when idle, else after stop
   assign load_shift = hold_v_r & ~busy_r & tx_act;

   // Holding register; the ninth bit is captured when the byte is written.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_r <= `ASPTX_RST_BYTE;
         hold9_r <= 1'b0;
         hold_v_r <= 1'b0;
      end else if (!tx_act) begin
         hold_v_r <= 1'b0;
      end else if (hold_wr) begin
         // RULE6 byte write starts transmission
         hold_r <= hwdata[7:0];
         hold9_r <= d9_r;
         hold_v_r <= 1'b1;
      end else if (load_shift) begin
         hold_v_r <= 1'b0;
      end
   end

   // Shift register: start, data LSb first, optional ninth bit, stop.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_r <= 1'b0;
         tshift_r <= 11'h7FF;
         tph_r <= 4'h0;
         tbits_r <= 4'h0;
      end else if (!tx_act) begin
         busy_r <= 1'b0;
         tshift_r <= 11'h7FF;
      end else if (load_shift) begin
         busy_r <= 1'b1;
         tph_r <= 4'h0;
         // RULE2 nine-bit frame layout
         if (ctrl_r.t9) begin
            tshift_r <= {1'b1, hold9_r, hold_r, 1'b0};
            tbits_r <= 4'hB;
         end else begin
            tshift_r <= {2'b11, hold_r, 1'b0};
            tbits_r <= 4'hA;
         end
      end else if (busy_r && tick_r) begin
         tph_r <= tph_r + 4'h1;
         if (tph_r == `ASPTX_OVS_LAST) begin
            tshift_r <= {1'b1, tshift_r[10:1]};
            tbits_r <= tbits_r - 4'h1;
            if (tx_done) begin
               busy_r <= 1'b0;
            end
         end
      end
   end

   // Pin drive; idle mark is also inverted by the polarity bit.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         serial_out_pin <= 1'b1;
         serial_out_oe_n <= 1'b1;
      end else begin
         // RULE3 transmit polarity invert
         serial_out_pin <= (busy_r ? tshift_r[0] : 1'b1) ^ ctrl_r.inv;
         serial_out_oe_n <= ~(ctrl_r.pen & ~ctrl_r.sync);
      end
   end

   logic txe_flag;
   // RULE4 empty flag follows enable
   // RULE21 clear while a character waits or the transmitter is not active
   assign txe_flag = tx_act & ~hold_v_r;

   // Interrupt request, registered so the output comes from a flop.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_irq <= 1'b0;
      end else begin
         // RULE5 interrupt when all enables meet flag
         tx_irq <= txe_flag & txie_r & gie_r & pie_r;
      end
   end

   // ------------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------------
   asptx_rxst_t rst_r;
   logic [2:0] smp_r;
   logic prev_in_r;
   logic [3:0] rph_r, rbits_r;
   logic [8:0] rshift_r;
   asptx_char_t fifo_r [DEPTH];
   logic [1:0] cnt_r;
   logic wp_r, rp_r;
   logic ovr_r;
   logic centre, done_ok, push, ovf;
   asptx_char_t in_char;

   assign centre = tick_r & (rph_r == `ASPTX_OVS_LAST);
   assign done_ok = (rst_r == RX_STOP) & centre;
   assign ovf = done_ok & (cnt_r == 2'(DEPTH));
   assign push = done_ok & ~ovf;
   assign in_char.frm = ~maj3(smp_r);
   assign in_char.data = ctrl_r.rx9 ? rshift_r : {1'b0, rshift_r[8:1]};

   // RULE8 sixteen oversample ticks per bit
   // RULE24 three-sample history for majority
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         smp_r <= 3'h7;
         prev_in_r <= 1'b1;
      end else begin
         prev_in_r <= serial_in_pin;
         if (tick_r) begin
            smp_r <= {smp_r[1:0], serial_in_pin};
         end
      end
   end

   // Bit recovery state machine.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_r <= RX_IDLE;
         rph_r <= 4'h0;
         rbits_r <= 4'h0;
         rshift_r <= 9'h000;
      end else if (!rx_act) begin
         rst_r <= RX_IDLE;
      end else begin
         if (tick_r) begin
            rph_r <= rph_r + 4'h1;
         end
         case (rst_r)
            RX_IDLE: begin
               // RULE11 falling edge starts reception
               // RULE18 no reception while overrun pending
               if (prev_in_r && !serial_in_pin && !ovr_r) begin
                  rst_r <= RX_START;
                  rph_r <= 4'h0;
               end
            end
            RX_START: begin
               // RULE12 half-bit start check
               if (tick_r && rph_r == `ASPTX_START_MID) begin
                  rph_r <= 4'h0;
                  // RULE13 silent abort on high centre
                  if (maj3({smp_r[1:0], serial_in_pin})) begin
                     rst_r <= RX_IDLE;
                  end else begin
                     rst_r <= RX_DATA;
                     rbits_r <= ctrl_r.rx9 ? 4'h9 : 4'h8;
                  end
               end
            end
            RX_DATA: begin
               // RULE14 full bit spacing, majority, shift
               if (centre) begin
                  rshift_r <= {maj3({smp_r[1:0], serial_in_pin}),
                               rshift_r[8:1]};
                  rbits_r <= rbits_r - 4'h1;
                  if (rbits_r == 4'h1) begin
                     rst_r <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (centre) begin
                  rst_r <= RX_IDLE;
               end
            end
            default: rst_r <= RX_IDLE;
         endcase
      end
   end

   // Stop decision reads the shifted history so it lags one tick; the
   // window still lies within the stop bit, traded for a shared path.
   // RULE15 stop sample sets framing status
   // RULE9 two-entry FIFO storage
   // RULE16 push right after stop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= 1'b0;
      end else if (!ctrl_r.pen) begin
         wp_r <= 1'b0;
      end else if (push) begin
         fifo_r[wp_r] <= in_char;
         wp_r <= ~wp_r;
      end
   end

   logic pop_ok;
   assign pop_ok = rd_pop & (cnt_r != 2'h0);

   // Read pointer and occupancy; port disable empties the FIFO.
   // RULE17 read removes oldest character
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else if (!ctrl_r.pen) begin
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (pop_ok) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop_ok};
      end
   end

   // RULE22 overrun set, cleared by disable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovr_r <= 1'b0;
      end else if (ovf) begin
         ovr_r <= 1'b1;
      end else if (!ctrl_r.rxon || !ctrl_r.pen) begin
         ovr_r <= 1'b0;
      end
   end

   logic frm_top, rxa_flag;
   asptx_char_t top;
   assign top = fifo_r[rp_r];
   // RULE23 framing flag follows oldest entry
   assign frm_top = (cnt_r != 2'h0) & top.frm;
   assign rxa_flag = cnt_r != 2'h0;

   // ------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------
   // Read data for the addressed register; missing bits stay zero.
   // RULE19 unimplemented bits read zero
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (haddr[7:0] == `ASPTX_OFS_TXSC) begin
         rdata_nxt[`ASPTX_TX_NINE] = ctrl_r.t9;
         rdata_nxt[`ASPTX_TX_EN] = ctrl_r.txon;
         rdata_nxt[`ASPTX_TX_SYNC] = ctrl_r.sync;
         rdata_nxt[`ASPTX_TX_FAST] = ctrl_r.fast;
         rdata_nxt[`ASPTX_TX_TRMT] = ~busy_r;
         rdata_nxt[`ASPTX_TX_D9] = d9_r;
      end else if (haddr[7:0] == `ASPTX_OFS_RXSC) begin
         rdata_nxt[`ASPTX_RX_PEN] = ctrl_r.pen;
         rdata_nxt[`ASPTX_RX_NINE] = ctrl_r.rx9;
         rdata_nxt[`ASPTX_RX_REN] = ctrl_r.rxon;
         rdata_nxt[`ASPTX_RX_FRM] = frm_top;
         rdata_nxt[`ASPTX_RX_OVR] = ovr_r;
         rdata_nxt[`ASPTX_RX_D9] = rxa_flag & top.data[8];
      end else if (haddr[7:0] == `ASPTX_OFS_BAUD) begin
         rdata_nxt[`ASPTX_BD_INV] = ctrl_r.inv;
         rdata_nxt[`ASPTX_BD_WIDE] = ctrl_r.wide;
      end else if (haddr[7:0] == `ASPTX_OFS_DIVL) begin
         rdata_nxt[7:0] = divl_r;
      end else if (haddr[7:0] == `ASPTX_OFS_DIVH) begin
         rdata_nxt[7:0] = divh_r;
      end else if (haddr[7:0] == `ASPTX_OFS_TXH) begin
         rdata_nxt[7:0] = hold_r;
      end else if (haddr[7:0] == `ASPTX_OFS_RXR) begin
         rdata_nxt[7:0] = rxa_flag ? top.data[7:0] : 8'h00;
      end else if (haddr[7:0] == `ASPTX_OFS_FLAG) begin
         rdata_nxt[`ASPTX_FL_TXE] = txe_flag;
         rdata_nxt[`ASPTX_FL_RXA] = rxa_flag;
         rdata_nxt[`ASPTX_FL_TXIE] = txie_r;
         rdata_nxt[`ASPTX_FL_GIE] = gie_r;
         rdata_nxt[`ASPTX_FL_PIE] = pie_r;
      end
   end

   // Zero-wait slave: read data is latched at the address phase so the
   // data phase shows it from a flop; writes commit in the data phase.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= take & hwrite;
         wr_addr_r <= haddr[7:0];
         if (take && !hwrite) begin
            hrdata <= rdata_nxt;
         end
      end
   end

   // Software-written control registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= '0;
         divl_r <= `ASPTX_RST_BYTE;
         divh_r <= `ASPTX_RST_BYTE;
         d9_r <= 1'b0;
         txie_r <= 1'b0;
         gie_r <= 1'b0;
         pie_r <= 1'b0;
      end else if (wr_pend_r) begin
         if (wr_addr_r == `ASPTX_OFS_TXSC) begin
            ctrl_r.t9 <= hwdata[`ASPTX_TX_NINE];
            ctrl_r.txon <= hwdata[`ASPTX_TX_EN];
            ctrl_r.sync <= hwdata[`ASPTX_TX_SYNC];
            ctrl_r.fast <= hwdata[`ASPTX_TX_FAST];
            d9_r <= hwdata[`ASPTX_TX_D9];
         end else if (wr_addr_r == `ASPTX_OFS_RXSC) begin
            ctrl_r.pen <= hwdata[`ASPTX_RX_PEN];
            ctrl_r.rx9 <= hwdata[`ASPTX_RX_NINE];
            ctrl_r.rxon <= hwdata[`ASPTX_RX_REN];
         end else if (wr_addr_r == `ASPTX_OFS_BAUD) begin
            ctrl_r.inv <= hwdata[`ASPTX_BD_INV];
            ctrl_r.wide <= hwdata[`ASPTX_BD_WIDE];
         end else if (wr_addr_r == `ASPTX_OFS_DIVL) begin
            divl_r <= hwdata[7:0];
         end else if (wr_addr_r == `ASPTX_OFS_DIVH) begin
            divh_r <= hwdata[7:0];
         end else if (wr_addr_r == `ASPTX_OFS_FLAG) begin
            txie_r <= hwdata[`ASPTX_FL_TXIE];
            gie_r <= hwdata[`ASPTX_FL_GIE];
            pie_r <= hwdata[`ASPTX_FL_PIE];
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_irq;
      @(posedge clk) disable iff (!arst_n)
      (txe_flag & txie_r & gie_r & pie_r) |=> tx_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised"); // RULE5

   property p_txe;
      @(posedge clk) disable iff (!arst_n)
      $rose(tx_act) |-> txe_flag;
   endproperty
   a_txe: assert property (p_txe) else $error("empty flag low"); // RULE4

   property p_load;
      @(posedge clk) disable iff (!arst_n)
      (hold_wr & ~busy_r & tx_act) |=> ##1 busy_r;
   endproperty
   a_load: assert property (p_load) else $error("no shift load"); // RULE20

   property p_ovf;
      @(posedge clk) disable iff (!arst_n)
      (done_ok && cnt_r == 2'h2) |=>
         ovr_r && cnt_r == 2'h2 - {1'b0, $past(pop_ok)};
   endproperty
   a_ovf: assert property (p_ovf) else $error("overrun missed"); // RULE22

   property p_block;
      @(posedge clk) disable iff (!arst_n)
      ovr_r |-> (rst_r == RX_IDLE) ##1 (rst_r != RX_START);
   endproperty
   a_block: assert property (p_block) else $error("rx during ovr"); // RULE18

   property p_push;
      @(posedge clk) disable iff (!arst_n)
      (done_ok && cnt_r == 2'h0 && !pop_ok) |=> rxa_flag;
   endproperty
   a_push: assert property (p_push) else $error("char not queued"); // RULE16

   property p_pop;
      @(posedge clk) disable iff (!arst_n)
      (pop_ok && !push) |=> cnt_r == $past(cnt_r) - 2'h1;
   endproperty
   a_pop: assert property (p_pop) else $error("pop failed"); // RULE17

   property p_rxoff;
      @(posedge clk) disable iff (!arst_n)
      !rx_act |=> rst_r == RX_IDLE;
   endproperty
   a_rxoff: assert property (p_rxoff) else $error("rx not idle"); // RULE10

   property p_abort;
      @(posedge clk) disable iff (!arst_n)
      (rx_act && rst_r == RX_START && tick_r && rph_r == `ASPTX_START_MID &&
       maj3({smp_r[1:0], serial_in_pin})) |=> rst_r == RX_IDLE && !ovr_r;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort"); // RULE13

   property p_idle_line;
      @(posedge clk) disable iff (!arst_n)
      (!busy_r && !$past(busy_r)) |=> serial_out_pin == ~$past(ctrl_r.inv);
   endproperty
   a_idle_line: assert property (p_idle_line) else $error("bad idle"); // RULE3

endmodule : asptx_top

// ---- asptx_remote_node.sv ----
// Remote serial node: frames bytes onto the device receive line and
// captures frames from the device transmit line.
// Assumes one bit lasts BIT_CLKS cycles of clk in both directions.
module asptx_remote_node #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk, // Bench clock.
   input wire logic line_in, // Device transmit line.
   input wire logic nine, // Expect nine data bits.
   output logic line_out // Device receive line, idles at mark.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] rxq[$];
   logic [8:0] sh;
   initial line_out = 1'b1;
   // Capture, LSb first.
   // Samples at bit centres, so a slow or early edge still decodes.
   initial begin
      forever begin
         @(negedge line_in);
         repeat (BIT_CLKS / 2) @(posedge clk);
         sh = 9'h000;
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            sh[i] = line_in;
         end
         repeat (BIT_CLKS) @(posedge clk);
         rxq.push_back(sh);
      end
   end
   // Shared bit period.
   // Sends start, eight data bits LSb first, then the given stop level.
   task automatic send(input logic [7:0] b, input logic stop_bit);
      logic [9:0] f;
      f = {stop_bit, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      // One idle clock keeps two back-to-back frames from writing the
      // line twice in one time step.
      line_out <= 1'b1;
      @(posedge clk);
   endtask : send
   // A low pulse shorter than half a bit, to look like noise.
   task automatic glitch(input int n);
      line_out <= 1'b0;
      repeat (n) @(posedge clk);
      line_out <= 1'b1;
   endtask : glitch
endmodule : asptx_remote_node

// ---- test_async_serial_tx_rx_port.sv ----
// Self-checking bench for the serial port, driven over AHB-Lite.
// Assumes divisor 0 with fast select, so one bit is sixteen clocks.
`include "asptx_consts.svh"
module test_async_serial_tx_rx_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, ser_rx, ser_tx, oe_n, tx_irq;
   logic nine = 1'b0;
   logic [7:0] b[4];
   int n_mismatch = 0;
   int num_checks = 0;
   asptx_top asptx_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(ser_rx),
      .serial_out_pin(ser_tx), .serial_out_oe_n(oe_n), .tx_irq(tx_irq));
   asptx_remote_node asptx_remote_node_inst (.clk(clk), .line_in(ser_tx),
      .nine(nine), .line_out(ser_rx));
   // Clock of 50 ns period.
   always #25 clk = ~clk;
   // --------------------------------------------------------------
   // Bus and check tasks
   // --------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One single transfer; waits on ready in both phases.
   task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic rd(input string nm, logic [7:0] a, logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask : rd
   // Polls a register under a bounded count until a field matches.
   task automatic waitf(input logic [7:0] a, logic [31:0] m, e);
      for (int i = 0; i < 400; i++) begin
         bus(1'b0, a, 32'h0);
         if ((q & m) === e) break;
      end
      chk("poll", e, q & m);
   endtask : waitf
   function automatic logic [31:0] rxv(input logic [7:0] v);
      return {24'h000000, v};
   endfunction : rxv
   // Oldest character that the remote node captured.
   function automatic logic [31:0] qf();
      return 32'(asptx_remote_node_inst.rxq.pop_front());
   endfunction : qf
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   // Watchdog: the tests need well under 10000 cycles.
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      results();
   end
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      void'($urandom(34));
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b1, `ASPTX_OFS_DIVL, 32'h0);
      bus(1'b1, `ASPTX_OFS_DIVH, 32'hA5);
      rd("divisor high", `ASPTX_OFS_DIVH, '1, 32'hA5);
      rd("unmapped", 8'h20, '1, 32'h0);
      chk("okay", 32'h0, {31'h0, hresp});
      bus(1'b1, `ASPTX_OFS_RXSC, 32'h90);
      bus(1'b1, `ASPTX_OFS_TXSC, 32'h24);
      chk("pin enable", 32'h0, {31'h0, oe_n});
      rd("tx empty", `ASPTX_OFS_FLAG, 32'h1, 32'h1);
      bus(1'b1, `ASPTX_OFS_FLAG, 32'h1C);
      repeat (2) @(posedge clk);
      chk("tx irq", 32'h1, {31'h0, tx_irq});
      $display("setup done");
      for (int i = 0; i < 4; i++) b[i] = 8'($urandom);
      bus(1'b1, `ASPTX_OFS_TXH, rxv(b[0]));
      bus(1'b1, `ASPTX_OFS_TXH, rxv(b[1]));
      rd("tx full", `ASPTX_OFS_FLAG, 32'h1, 32'h0);
      waitf(`ASPTX_OFS_FLAG, 32'h1, 32'h1);
      bus(1'b1, `ASPTX_OFS_TXH, rxv(b[2]));
      waitf(`ASPTX_OFS_FLAG, 32'h1, 32'h1);
      waitf(`ASPTX_OFS_TXSC, 32'h2, 32'h2);
      for (int i = 0; i < 3; i++) begin
         chk("tx char", rxv(b[i]), qf());
      end
      nine <= 1'b1;
      bus(1'b1, `ASPTX_OFS_TXSC, 32'h65);
      bus(1'b1, `ASPTX_OFS_TXH, rxv(b[3]));
      waitf(`ASPTX_OFS_TXSC, 32'h2, 32'h2);
      chk("tx nine", {24'h000001, b[3]}, qf());
      nine <= 1'b0;
      $display("transmit done");
      asptx_remote_node_inst.send(b[0], 1'b1);
      asptx_remote_node_inst.send(b[1], 1'b0);
      repeat (16) @(posedge clk);
      rd("rx avail", `ASPTX_OFS_FLAG, 32'h2, 32'h2);
      rd("framing_error_flag one", `ASPTX_OFS_RXSC, 32'h4, 32'h0);
      rd("rx one", `ASPTX_OFS_RXR, '1, rxv(b[0]));
      rd("framing_error_flag two", `ASPTX_OFS_RXSC, 32'h4, 32'h4);
      rd("rx two", `ASPTX_OFS_RXR, '1, rxv(b[1]));
      asptx_remote_node_inst.glitch(4);
      repeat (40) @(posedge clk);
      rd("rx after glitch", `ASPTX_OFS_FLAG, 32'h2, 32'h0);
      for (int i = 0; i < 4; i++) asptx_remote_node_inst.send(b[i], 1'b1);
      repeat (16) @(posedge clk);
      rd("overrun", `ASPTX_OFS_RXSC, 32'h2, 32'h2);
      rd("rx keep one", `ASPTX_OFS_RXR, '1, rxv(b[0]));
      rd("rx keep two", `ASPTX_OFS_RXR, '1, rxv(b[1]));
      rd("rx dropped", `ASPTX_OFS_FLAG, 32'h2, 32'h0);
      bus(1'b1, `ASPTX_OFS_RXSC, 32'h80);
      rd("overrun clear", `ASPTX_OFS_RXSC, 32'h2, 32'h0);
      $display("receive done");
      bus(1'b1, `ASPTX_OFS_BAUD, 32'h10);
      repeat (3) @(posedge clk);
      chk("inverted idle", 32'h0, {31'h0, ser_tx});
      bus(1'b1, `ASPTX_OFS_TXSC, 32'h34);
      repeat (3) @(posedge clk);
      chk("clocked mode", 32'h1, {31'h0, oe_n});
      $display("mode done");
      results();
   end
endmodule : test_async_serial_tx_rx_port
